/* File: src/dss_params.svh */
// Constants for the drive start sequencer
`ifndef DSS_PARAMS_SVH
`define DSS_PARAMS_SVH
`define DSS_CLK_MHZ 32'h000000fa
// One setting unit of time is 0.1 s
`define DSS_TENTH_S_NS 32'h05f5e100
`define DSS_TENTH_CYC 32'h017d7840
`define DSS_TIME_MAX 16'h03e8
`define DSS_FREQ_MAX 16'h03e8
`define DSS_PCT_MAX 8'h64
`define DSS_RATE_MIN 8'h01
`define DSS_RATE_MAX 8'h64
`define DSS_RATE_DEF 8'h02
`define DSS_RATE_SPAN 8'h64
`define DSS_METH_DIRECT 2'h0
`define DSS_METH_TRACK 2'h1
`define DSS_METH_EXCITE 2'h2
`define DSS_DIR_LOSS 2'h0
`define DSS_DIR_ZERO 2'h1
`define DSS_DIR_MAX 2'h2
`endif

/* File: src/dss_pkg.sv */
// Types for the drive start sequencer
package dss_pkg;
  typedef enum logic [2:0] {
    DSS_STANDBY = 3'h0,
    DSS_BRAKE = 3'h1,
    DSS_EXCITE = 3'h3,
    DSS_SEARCH = 3'h2,
    DSS_HOLD = 3'h6,
    DSS_RUN = 3'h7
  } dss_phase_t;
endpackage

/* File: src/dss_tick_if.sv */
// Timing tick between sequencer and its divider
`timescale 1ns/1ps
interface dss_tick_if;
  logic tenth;
  logic clear;
  modport src (output tenth, input clear);
  modport snk (input tenth, output clear);
endinterface

/* File: src/dss_tick_div.sv */
// Divider giving a one-cycle pulse every 0.1 s
`timescale 1ns/1ps
`include "dss_params.svh"
module dss_tick_div #(
  parameter int TENTH_CYC = `DSS_TENTH_CYC
) (
  input wire logic core_clk,
  input wire logic rstn,
  dss_tick_if.src tk
);
  logic [31:0] cnt;

  // Restart keeps every phase time aligned to its own start
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      cnt <= 32'h0;
      tk.tenth <= 1'b0;
    end else if (tk.clear || cnt == 32'(TENTH_CYC - 1)) begin
      cnt <= 32'h0;
      tk.tenth <= !tk.clear;
    end else begin
      cnt <= cnt + 32'h1;
      tk.tenth <= 1'b0;
    end
  end
endmodule

/* File: src/dss_seq.sv */
// Start-up sequencer for a motor frequency converter
`timescale 1ns/1ps
`include "dss_params.svh"
module dss_seq
  import dss_pkg::*;
#(
  parameter int TENTH_CYC = `DSS_TENTH_CYC,
  parameter int FW = 16
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic run_cmd,
  input wire logic reversal,
  input wire logic [1:0] start_method_select,
  input wire logic [1:0] search_direction_select,
  input wire logic [7:0] search_rate,
  input wire logic [FW-1:0] launch_frequency,
  input wire logic [15:0] launch_hold_time,
  input wire logic [7:0] brake_excite_current,
  input wire logic [15:0] brake_excite_time,
  input wire logic [FW-1:0] target_frequency,
  input wire logic [FW-1:0] loss_frequency,
  input wire logic [FW-1:0] max_frequency,
  input wire logic speed_match,
  output logic [FW-1:0] out_frequency,
  output logic [7:0] dc_current,
  output logic dc_brake_on,
  output logic excite_on,
  output logic accel_enable,
  output logic [2:0] phase
);
  // One shared tick; each phase restarts it so its time counts from entry
  dss_tick_if tk();
  dss_phase_t state;
  dss_phase_t next_state;
  logic [15:0] tcnt;
  logic [7:0] rate_acc;
  logic start_ok;
  logic search_down;

  dss_tick_div #(.TENTH_CYC(TENTH_CYC)) u_div (
    .core_clk(core_clk),
    .rstn(rstn),
    .tk(tk)
  );

  function automatic logic [15:0] clip_time(input logic [15:0] t);
    clip_time = (t > `DSS_TIME_MAX) ? `DSS_TIME_MAX : t;
  endfunction

  function automatic logic [FW-1:0] clip_freq(input logic [FW-1:0] f);
    clip_freq = (f > FW'(`DSS_FREQ_MAX)) ? FW'(`DSS_FREQ_MAX) : f;
  endfunction

  // Sum is taken one bit wider so a large rate cannot wrap past the span
  function automatic logic step_due(input logic [7:0] acc,
      input logic [7:0] r);
    step_due = ({1'b0, acc} + {1'b0, r}) >= {1'b0, `DSS_RATE_SPAN};
  endfunction

  // Settings are read live, so changing one mid-phase moves its end
  function automatic logic time_up(input logic [15:0] lim);
    time_up = (tcnt + 16'h1) >= clip_time(lim);
  endfunction

  logic [FW-1:0] launch_f;
  logic [7:0] rate;
  logic [7:0] cur_pct;
  assign launch_f = clip_freq(launch_frequency);
  // Out-of-range rate falls back to the safe default
  assign rate = (search_rate < `DSS_RATE_MIN || search_rate > `DSS_RATE_MAX)
    ? `DSS_RATE_DEF : search_rate;
  assign cur_pct = (brake_excite_current > `DSS_PCT_MAX)
    ? `DSS_PCT_MAX : brake_excite_current;
  // Compared against the clipped launch value, as that is what is driven
  assign start_ok = run_cmd && (target_frequency >= launch_f);
  assign search_down = (search_direction_select != `DSS_DIR_ZERO);

  // Hold phase is entered only on a fresh start, never on reversal
  function automatic dss_phase_t after_start(input logic rev);
    after_start = (rev || clip_time(launch_hold_time) == 16'h0)
      ? DSS_RUN : DSS_HOLD;
  endfunction

  // Dropping run_cmd wins over every phase, so a stop is never delayed
  always_comb begin
    next_state = state;
    case (state)
      DSS_STANDBY: begin
        if (start_ok) begin
          case (start_method_select)
            `DSS_METH_DIRECT: next_state =
              (clip_time(brake_excite_time) != 16'h0) ? DSS_BRAKE
              : after_start(reversal);
            `DSS_METH_TRACK: next_state = DSS_SEARCH;
            `DSS_METH_EXCITE: next_state =
              (clip_time(brake_excite_time) != 16'h0) ? DSS_EXCITE
              : after_start(reversal);
            default: next_state = after_start(reversal);
          endcase
        end
      end
      DSS_BRAKE, DSS_EXCITE: begin
        if (tk.tenth && time_up(brake_excite_time))
          next_state = after_start(reversal);
      end
      DSS_SEARCH: begin
        // Ending at 0 or max keeps a search with no match from hanging
        if (speed_match || (search_down && out_frequency == '0) ||
            (!search_down && out_frequency >= max_frequency))
          next_state = DSS_RUN;
      end
      DSS_HOLD: begin
        if (reversal || (tk.tenth && time_up(launch_hold_time)))
          next_state = DSS_RUN;
      end
      DSS_RUN: next_state = DSS_RUN;
      default: next_state = DSS_STANDBY;
    endcase
    if (!start_ok)
      next_state = DSS_STANDBY;
  end

  // Restarting the divider on entry avoids a short first tenth
  assign tk.clear = (next_state != state);

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn)
      state <= DSS_STANDBY;
    else
      state <= next_state;
  end

  // Phase timer in tenths of a second
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn)
      tcnt <= 16'h0;
    else if (next_state != state)
      tcnt <= 16'h0;
    else if (tk.tenth)
      tcnt <= tcnt + 16'h1;
  end

  // Search steps one unit every ceil(100 / rate) tenths; coarse but monotonic
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn)
      rate_acc <= 8'h0;
    else if (state != DSS_SEARCH || tk.clear)
      rate_acc <= 8'h0;
    else if (tk.tenth)
      rate_acc <= step_due(rate_acc, rate) ? 8'h0 : rate_acc + rate;
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn)
      out_frequency <= '0;
    // No frequency while idle or while DC current alone is applied
    else if (next_state == DSS_STANDBY || next_state == DSS_BRAKE ||
             next_state == DSS_EXCITE)
      out_frequency <= '0;
    else if (next_state == DSS_SEARCH && state == DSS_STANDBY) begin
      // Start point is taken once; later the direction only sets the step
      case (search_direction_select)
        `DSS_DIR_LOSS: out_frequency <= loss_frequency;
        `DSS_DIR_ZERO: out_frequency <= '0;
        default: out_frequency <= max_frequency;
      endcase
    end else if (state == DSS_SEARCH && next_state == DSS_SEARCH) begin
      if (tk.tenth && step_due(rate_acc, rate)) begin
        if (search_down)
          out_frequency <= out_frequency - FW'(1);
        else
          out_frequency <= out_frequency + FW'(1);
      end
    end else if (next_state == DSS_HOLD ||
             (next_state == DSS_RUN && state != DSS_RUN &&
              state != DSS_SEARCH))
      out_frequency <= launch_f;
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      dc_brake_on <= 1'b0;
      excite_on <= 1'b0;
      dc_current <= 8'h0;
    end else begin
      dc_brake_on <= (next_state == DSS_BRAKE);
      excite_on <= (next_state == DSS_EXCITE);
      // Brake and excite share one current setting
      dc_current <= (next_state == DSS_BRAKE || next_state == DSS_EXCITE)
        ? cur_pct : 8'h0;
    end
  end

  // Acceleration ramp only runs in the run phase, so hold time is excluded
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      accel_enable <= 1'b0;
      phase <= 3'h0;
    end else begin
      accel_enable <= (next_state == DSS_RUN);
      phase <= next_state;
    end
  end
endmodule

/* File: testbench/dss_seq_sva.sv */
// Port assertions for the start sequencer
`timescale 1ns/1ps
module dss_seq_sva
  import dss_pkg::*;
#(
  parameter int FW = 16
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic run_cmd,
  input wire logic reversal,
  input wire logic [1:0] start_method_select,
  input wire logic [FW-1:0] launch_frequency,
  input wire logic [15:0] launch_hold_time,
  input wire logic [7:0] brake_excite_current,
  input wire logic [15:0] brake_excite_time,
  input wire logic [FW-1:0] target_frequency,
  input wire logic [FW-1:0] out_frequency,
  input wire logic [7:0] dc_current,
  input wire logic dc_brake_on,
  input wire logic excite_on,
  input wire logic accel_enable,
  input wire logic [2:0] phase
);
  logic ok;
  // Clipped settings are left out so only exact figures are judged
  assign ok = target_frequency >= launch_frequency &&
    launch_frequency <= 16'h03e8 && brake_excite_time <= 16'h03e8;
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!rstn);
  stby_zero_a: assert property (phase == DSS_STANDBY |->
    out_frequency == '0 && !accel_enable) else $error("standby output");
  drop_stby_a: assert property (!run_cmd |=> phase == DSS_STANDBY)
    else $error("no standby on drop");
  direct_a: assert property ($rose(run_cmd) && ok &&
    start_method_select == 2'h0 && brake_excite_time == 16'h0000 &&
    (launch_hold_time == 16'h0000 || reversal) |=> phase == DSS_RUN &&
    out_frequency == $past(launch_frequency)) else $error("direct start");
  brake_a: assert property ($rose(run_cmd) && ok &&
    start_method_select == 2'h0 && brake_excite_time != 16'h0000 |=>
    phase == DSS_BRAKE && dc_brake_on) else $error("brake phase");
  excite_a: assert property ($rose(run_cmd) && ok &&
    start_method_select == 2'h2 && brake_excite_time != 16'h0000 |=>
    phase == DSS_EXCITE && excite_on) else $error("excite phase");
  search_a: assert property ($rose(run_cmd) && ok &&
    start_method_select == 2'h1 |=> phase == DSS_SEARCH)
    else $error("search phase");
  dc_pct_a: assert property ((dc_brake_on || excite_on) &&
    brake_excite_current <= 8'h64 |-> dc_current == brake_excite_current)
    else $error("dc current");
  brake_only_a: assert property (dc_brake_on |->
    phase == DSS_BRAKE && !excite_on) else $error("brake outside phase");
  accel_a: assert property (accel_enable == (phase == DSS_RUN))
    else $error("accel outside run");
endmodule
bind dss_seq dss_seq_sva #(.FW(FW)) dss_seq_sva_i (.*);

/* File: testbench/dss_motor_model.sv */
// Motor model flagging a speed match during search
`timescale 1ns/1ps
module dss_motor_model
  import dss_pkg::*;
(
  input wire logic [2:0] phase,
  input wire logic [15:0] out_frequency,
  input wire logic [15:0] motor_freq,
  output logic speed_match
);
  // A match means nothing outside search, so it is held low there
  assign speed_match = phase == DSS_SEARCH && out_frequency == motor_freq;
endmodule

/* File: testbench/dss_seq_tb.sv */
// Self-checking bench for the start sequencer
`timescale 1ns/1ps
module dss_seq_tb;
  import dss_pkg::*;
  logic core_clk = 0, rstn = 0, run_cmd = 0, reversal = 0, speed_match;
  logic [1:0] start_method_select = 0, search_direction_select = 0;
  logic [7:0] search_rate = 8'h64, brake_excite_current = 8'h00;
  logic [15:0] launch_frequency = 0, launch_hold_time = 0, mf = 0;
  logic [15:0] brake_excite_time = 0, target_frequency = 0;
  logic [15:0] loss_frequency = 0, max_frequency = 0, out_frequency;
  logic [7:0] dc_current;
  logic dc_brake_on, excite_on, accel_enable;
  logic [2:0] phase;
  logic [31:0] seed = 32'h00000054;
  int bad_count = 0, checked = 0;
  dss_seq #(.TENTH_CYC(4)) dss_seq_i (.core_clk, .rstn, .run_cmd,
    .reversal, .start_method_select, .search_direction_select,
    .search_rate, .launch_frequency, .launch_hold_time,
    .brake_excite_current, .brake_excite_time, .target_frequency,
    .loss_frequency, .max_frequency, .speed_match, .out_frequency,
    .dc_current, .dc_brake_on, .excite_on, .accel_enable, .phase);
  dss_motor_model dss_motor_model_i (.phase, .out_frequency,
    .motor_freq(mf), .speed_match);
  initial begin
    forever #2 core_clk = ~core_clk;
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  task automatic chk(input string n, input logic [15:0] e, g);
    checked++;
    if (g !== e) begin
      bad_count++;
      $display("FAIL %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // Reference model: first phase from the rules, settings as integers
  function automatic logic [15:0] ref_phase(input int m, b, h, rv);
    int lf;
    lf = launch_frequency > 16'h03e8 ? 16'h03e8 : launch_frequency;
    if (target_frequency < lf)
      return 16'(DSS_STANDBY);
    if (m == 1)
      return 16'(DSS_SEARCH);
    if (m == 0 && b != 0)
      return 16'(DSS_BRAKE);
    if (m == 2 && b != 0)
      return 16'(DSS_EXCITE);
    return (h != 0 && rv == 0) ? 16'(DSS_HOLD) : 16'(DSS_RUN);
  endfunction
  // Generous wait: search steps need one tick each at rate 100, fifty at the fallback rate
  task automatic run(input logic [1:0] m, input logic [15:0] b, h,
      input logic rv, input dss_phase_t p1, p2, input logic [15:0] f1, f2);
    @(negedge core_clk);
    start_method_select = m;
    brake_excite_time = b;
    launch_hold_time = h;
    reversal = rv;
    run_cmd = 1;
    repeat (2) @(negedge core_clk);
    chk("phase", {13'h0, p1}, {13'h0, phase});
    chk("model", ref_phase(m, b, h, rv), {13'h0, phase});
    chk("freq", f1, out_frequency);
    chk("dc", p1 inside {DSS_BRAKE, DSS_EXCITE} ? {8'h0,
      (brake_excite_current > 8'h64 ? 8'h64 : brake_excite_current)} :
      16'h0, {8'h0, dc_current});
    chk("brake", {15'h0, p1 == DSS_BRAKE}, {15'h0, dc_brake_on});
    chk("excite", {15'h0, p1 == DSS_EXCITE}, {15'h0, excite_on});
    repeat (300 + 4 * (b + h)) @(negedge core_clk);
    chk("phase", {13'h0, p2}, {13'h0, phase});
    chk("freq", f2, out_frequency);
    chk("accel", {15'h0, p2 == DSS_RUN}, {15'h0, accel_enable});
    run_cmd = 0;
    repeat (2) @(negedge core_clk);
    chk("phase", 16'h0, {13'h0, phase});
  endtask
  initial begin
    #60000;
    bad_count++;
    test_done();
  end
  initial begin
    repeat (20) @(negedge core_clk);
    rstn = 1;
    seed = xs(seed);
    launch_frequency = {8'h0, seed[7:0]} + 16'h0001;
    brake_excite_current = {3'h0, seed[12:8]} + 8'h28;
    target_frequency = launch_frequency;
    run(0, 0, 0, 0, DSS_RUN, DSS_RUN,
      launch_frequency, launch_frequency);
    run(0, 2, 0, 0, DSS_BRAKE, DSS_RUN, 0, launch_frequency);
    run(0, 0, 3, 0, DSS_HOLD, DSS_RUN,
      launch_frequency, launch_frequency);
    run(0, 0, 3, 1, DSS_RUN, DSS_RUN,
      launch_frequency, launch_frequency);
    run(2, 0, 0, 0, DSS_RUN, DSS_RUN,
      launch_frequency, launch_frequency);
    run(3, 2, 0, 0, DSS_RUN, DSS_RUN,
      launch_frequency, launch_frequency);
    run(2, 3, 0, 0, DSS_EXCITE, DSS_RUN, 0, launch_frequency);
    for (int d = 0; d < 4; d++) begin
      seed = xs(seed);
      mf = {12'h0, seed[3:0]} + 16'h0004;
      loss_frequency = mf + 16'h0003;
      max_frequency = mf + 16'h0005;
      search_direction_select = d[1:0];
      run(1, 0, 0, 0, DSS_SEARCH, DSS_RUN,
        d == 0 ? loss_frequency : d == 1 ? 16'h0 : max_frequency, mf);
    end
    // Out-of-range rate must fall back to the slow default and still finish
    search_rate = 8'h00;
    search_direction_select = 2'h0;
    run(1, 0, 200, 0, DSS_SEARCH, DSS_RUN, loss_frequency, mf);
    target_frequency = launch_frequency - 16'h0001;
    run(0, 0, 0, 0, DSS_STANDBY, DSS_STANDBY, 0, 0);
    launch_frequency = 16'h0400;
    target_frequency = 16'h03e8;
    brake_excite_current = 8'hc8;
    run(0, 2, 0, 0, DSS_BRAKE, DSS_RUN, 0, 16'h03e8);
    test_done();
  end
endmodule
